// ### bim_irq_mask.sv
// Bridge interrupt mask/decode register, interrupt status gating and PM capability header.
// Assumes the status register blocks pulse the bits they set; the local bus is single cycle.
`timescale 1ns/1ps

module bim_irq_mask (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Core local bus
  input wire logic BUS_RD,
  input wire logic BUS_WR,
  input wire logic [15:0] BUS_ADDR,
  input wire logic [3:0] BUS_BE,
  input wire logic [31:0] BUS_WDATA,
  output logic [31:0] BUS_RDATA,
  output logic BUS_ACK,
  // Status events from the bus interfaces
  input wire bim_pkg::bim_evt_s PRI_EVT,
  input wire bim_pkg::bim_evt_s SEC_EVT,
  // Power state written by software and bridge control reset bit
  input wire logic PS_WR,
  input wire logic [1:0] PS_NEW,
  input wire logic SEC_RST_BIT,
  // Outputs to the bridge
  output logic PRIVATE_SPACE,
  output logic CAP_LIST_PRESENT,
  output logic [6:0] PRI_IRQ_STATUS,
  output logic [6:0] SEC_IRQ_STATUS
);
  import bim_pkg::*;

  logic [15:0] mask_q;
  logic [1:0] ps_q;
  logic srst_q;
  logic [6:0] pri_q, sec_q;
  logic [6:0] pri_set, sec_set;
  logic pri_clr_wr, sec_clr_wr;

  // ==========================================
  // Decode helpers
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a[15:2] == r[15:2]);
  endfunction

  function automatic logic [6:0] gate(input logic [15:0] st, input logic ext,
                                      input logic [6:0] m);
    gate = {ext, st[ST_DPE], st[ST_SERR], st[ST_MABT], st[ST_TABM], st[ST_TABT],
            st[ST_MPE]} & ~m;
  endfunction

  // ==========================================
  // Event gating
  always_comb begin
    sec_set = gate(SEC_EVT.status_set, srst_q & ~SEC_RST_BIT,
                   {mask_q[MB_SRST], mask_q[MB_SDPE], mask_q[MB_SSERR], mask_q[MB_SMABT],
                    mask_q[MB_STABM], mask_q[MB_STABT], mask_q[MB_SMPE]});
    pri_set = gate(PRI_EVT.status_set,
                   PS_WR & (((ps_q == PS_D0) && (PS_NEW == PS_D3)) ||
                            ((ps_q == PS_D3) && (PS_NEW == PS_D0))),
                   {mask_q[MB_PST], mask_q[MB_PDPE], mask_q[MB_PSERR], mask_q[MB_PMABT],
                    mask_q[MB_PTABM], mask_q[MB_PTABT], mask_q[MB_PMPE]});
    pri_clr_wr = BUS_WR && hit(BUS_ADDR, ADDR_PRI_IRQ) && BUS_BE[0];
    sec_clr_wr = BUS_WR && hit(BUS_ADDR, ADDR_SEC_IRQ) && BUS_BE[0];
  end

  // ==========================================
  // Mask and decode register
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mask_q <= MASK_RESET;
    end else if (BUS_WR && hit(BUS_ADDR, ADDR_MASK_DECODE)) begin
      if (BUS_BE[0]) begin
        mask_q[7:0] <= BUS_WDATA[7:0] & MASK_WR_BITS[7:0];
      end
      if (BUS_BE[1]) begin
        mask_q[15:8] <= BUS_WDATA[15:8];
      end
    end
  end

  // Power state and secondary reset history
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ps_q <= PS_D0;
      srst_q <= 1'b0;
    end else begin
      srst_q <= SEC_RST_BIT;
      if (PS_WR) begin
        ps_q <= PS_NEW;
      end
    end
  end

  // Interrupt status, write one to clear, set wins
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pri_q <= 7'h00;
      sec_q <= 7'h00;
    end else begin
      pri_q <= (pri_q & ~(pri_clr_wr ? BUS_WDATA[6:0] : 7'h00)) | pri_set;
      sec_q <= (sec_q & ~(sec_clr_wr ? BUS_WDATA[6:0] : 7'h00)) | sec_set;
    end
  end

  // ==========================================
  // Read path
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      BUS_RDATA <= 32'h00000000;
      BUS_ACK <= 1'b0;
    end else begin
      BUS_ACK <= BUS_RD | BUS_WR;
      BUS_RDATA <= 32'h00000000;
      if (BUS_RD) begin
        if (hit(BUS_ADDR, ADDR_MASK_DECODE)) begin
          BUS_RDATA <= {16'h0000, mask_q};
        end else if (hit(BUS_ADDR, ADDR_PM_CAPABILITY_IDENTIFIER)) begin
          BUS_RDATA <= {PM_CAPS_VAL, CAP_NEXT_VAL, PM_CAPABILITY_IDENTIFIER_VAL};
        end else if (hit(BUS_ADDR, ADDR_CAP_PTR)) begin
          BUS_RDATA <= {24'h000000, CAP_PTR_VAL};
        end else if (hit(BUS_ADDR, ADDR_PRI_IRQ)) begin
          BUS_RDATA <= {25'h0000000, pri_q};
        end else if (hit(BUS_ADDR, ADDR_SEC_IRQ)) begin
          BUS_RDATA <= {25'h0000000, sec_q};
        end
      end
    end
  end

  // ==========================================
  // Outputs
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PRIVATE_SPACE <= 1'b0;
      CAP_LIST_PRESENT <= 1'b0;
      PRI_IRQ_STATUS <= 7'h00;
      SEC_IRQ_STATUS <= 7'h00;
    end else begin
      PRIVATE_SPACE <= mask_q[MB_PRIV];
      CAP_LIST_PRESENT <= 1'b1;
      PRI_IRQ_STATUS <= pri_q;
      SEC_IRQ_STATUS <= sec_q;
    end
  end

endmodule

// ### bim_irq_mask_assertions.sv
// Checker for the interrupt status, private-space and capability outputs.
// Assumes the single-cycle local bus and the registered status outputs.
`timescale 1ns/1ps
module bim_irq_mask_chk
  import bim_pkg::*;
(
  // Clock, reset and inputs
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic BUS_RD,
  input wire logic BUS_WR,
  input wire logic [15:0] BUS_ADDR,
  input wire bim_pkg::bim_evt_s PRI_EVT,
  input wire bim_pkg::bim_evt_s SEC_EVT,
  input wire logic PS_WR,
  input wire logic SEC_RST_BIT,
  // Watched outputs
  input wire logic [31:0] BUS_RDATA,
  input wire logic PRIVATE_SPACE,
  input wire logic CAP_LIST_PRESENT,
  input wire logic [6:0] PRI_IRQ_STATUS,
  input wire logic [6:0] SEC_IRQ_STATUS
);
  // ==========================================
  // Properties
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  pm_capability_identifier_a: assert property (BUS_RD && BUS_ADDR == 16'h1068 |=>
    BUS_RDATA == 32'h00020001) else $error("cap header word wrong");
  cap_ptr_a: assert property (BUS_RD && BUS_ADDR == 16'h1034 |=>
    BUS_RDATA == 32'h68) else $error("cap pointer wrong");
  sec_serr_a: assert property ($rose(SEC_IRQ_STATUS[4]) |->
    $past(SEC_EVT.status_set[14], 2)) else $error("sec bit4 without cause");
  pri_serr_a: assert property ($rose(PRI_IRQ_STATUS[4]) |->
    $past(PRI_EVT.status_set[14], 2)) else $error("pri bit4 without cause");
  pri_pstate_a: assert property ($rose(PRI_IRQ_STATUS[6]) |->
    $past(PS_WR, 2)) else $error("pri bit6 without power write");
  sec_reset_a: assert property ($rose(SEC_IRQ_STATUS[6]) |-> !$past(SEC_RST_BIT, 2) &&
    ($past(SEC_RST_BIT, 3) || $past(SEC_RST_BIT, 4))) else $error("sec bit6 without release");
  private_chg_a: assert property (!$stable(PRIVATE_SPACE) |->
    $past(BUS_WR) || $past(BUS_WR, 2)) else $error("private space moved alone");
  cap_list_a: assert property ($past(!SYS_RST) |-> CAP_LIST_PRESENT)
    else $error("capability list flag low");
  cover property ($rose(SEC_IRQ_STATUS[4]));
  cover property ($rose(PRI_IRQ_STATUS[6]));
  cover property ($rose(PRIVATE_SPACE));
endmodule
bind bim_irq_mask bim_irq_mask_chk i_chk (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
  .BUS_RD(BUS_RD), .BUS_WR(BUS_WR), .BUS_ADDR(BUS_ADDR), .PRI_EVT(PRI_EVT),
  .SEC_EVT(SEC_EVT), .PS_WR(PS_WR), .SEC_RST_BIT(SEC_RST_BIT), .BUS_RDATA(BUS_RDATA),
  .PRIVATE_SPACE(PRIVATE_SPACE), .CAP_LIST_PRESENT(CAP_LIST_PRESENT),
  .PRI_IRQ_STATUS(PRI_IRQ_STATUS), .SEC_IRQ_STATUS(SEC_IRQ_STATUS));

// ### bim_pkg.sv
// Constants and carrier types for the bridge interrupt mask and PM capability block.
// Assumes a byte-addressed core local bus with 32-bit data words.
package bim_pkg;

  // ==========================================
  // Register addresses
  localparam logic [15:0] ADDR_MASK_DECODE = 16'h105c;
  localparam logic [15:0] ADDR_PM_CAPABILITY_IDENTIFIER = 16'h1068;
  localparam logic [15:0] ADDR_CAP_NEXT = 16'h1069;
  localparam logic [15:0] ADDR_PM_CAPS = 16'h106a;
  localparam logic [15:0] ADDR_CAP_PTR = 16'h1034;
  localparam logic [15:0] ADDR_PRI_IRQ = 16'h1044;
  localparam logic [15:0] ADDR_SEC_IRQ = 16'h1048;

  // ==========================================
  // Reset and fixed values
  localparam logic [15:0] MASK_RESET = 16'hfffa;
  localparam logic [15:0] MASK_WR_BITS = 16'hfffe;
  localparam logic [7:0] PM_CAPABILITY_IDENTIFIER_VAL = 8'h01;
  localparam logic [7:0] CAP_NEXT_VAL = 8'h00;
  localparam logic [7:0] CAP_PTR_VAL = 8'h68;
  localparam logic [15:0] PM_CAPS_VAL = 16'h0002;

  // ==========================================
  // Mask bit positions
  localparam int MB_SSERR = 15;
  localparam int MB_SMABT = 14;
  localparam int MB_STABM = 13;
  localparam int MB_STABT = 12;
  localparam int MB_SMPE = 11;
  localparam int MB_PSERR = 10;
  localparam int MB_PMABT = 9;
  localparam int MB_PTABM = 8;
  localparam int MB_PTABT = 7;
  localparam int MB_PMPE = 6;
  localparam int MB_SDPE = 5;
  localparam int MB_PDPE = 4;
  localparam int MB_SRST = 3;
  localparam int MB_PRIV = 2;
  localparam int MB_PST = 1;

  // Bus status bit positions feeding the interrupt status bits 0..5
  localparam int ST_MPE = 8;
  localparam int ST_TABT = 11;
  localparam int ST_TABM = 12;
  localparam int ST_MABT = 13;
  localparam int ST_SERR = 14;
  localparam int ST_DPE = 15;
  localparam int IRQ_W = 7;
  localparam int IRQ_EXTRA = 6;
  localparam int ST_CAPLIST = 4;
  localparam logic [1:0] PS_D0 = 2'b00;
  localparam logic [1:0] PS_D3 = 2'b11;

  typedef struct packed {
    logic [15:0] status_set;
    logic extra_evt;
  } bim_evt_s;

endpackage

// ### bridge_irq_mask_pm_capability_tb.sv
// Self-checking bench: header reads, mask writes and event gating.
// Assumes a one-cycle bus answer and two-cycle status latency.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module bridge_irq_mask_pm_capability_tb;
  import bim_pkg::*;
  // ==========================================
  // Signals
  logic clk = 0, rst = 1, rd = 0, wr = 0, psw = 0, srb = 0, ack, priv, capl;
  logic [15:0] addr = 0;
  logic [31:0] wd = 0, rdat, r, m, seed = 32'h937eee22;
  logic [1:0] psn = 0;
  logic [6:0] pis, sis, ep, es;
  bim_evt_s pe = '0, se = '0;
  int miscompares = 0, total_checks = 0;
  int st[6] = '{8, 11, 12, 13, 14, 15}, pm[6] = '{6, 7, 8, 9, 10, 4};
  int sm[6] = '{11, 12, 13, 14, 15, 5};
  bim_irq_mask i_dut (.CORE_CLK(clk), .SYS_RST(rst), .BUS_RD(rd), .BUS_WR(wr),
    .BUS_ADDR(addr), .BUS_BE(4'hf), .BUS_WDATA(wd), .BUS_RDATA(rdat), .BUS_ACK(ack),
    .PRI_EVT(pe), .SEC_EVT(se), .PS_WR(psw), .PS_NEW(psn), .SEC_RST_BIT(srb),
    .PRIVATE_SPACE(priv), .CAP_LIST_PRESENT(capl), .PRI_IRQ_STATUS(pis),
    .SEC_IRQ_STATUS(sis));
  initial begin
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    `CHK(ack, 1'b1)
    r = rdat;
  endtask
  task automatic test_done();
    if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    test_done();
  end
  // ==========================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    bus(0, 16'h105c, 0); `CHK(r, 32'h0000fffa)
    bus(0, 16'h1068, 0); `CHK(r, 32'h00020001)
    bus(0, 16'h1034, 0); `CHK(r, 32'h68)
    bus(1, 16'h1068, xs()); bus(0, 16'h1068, 0); `CHK(r, 32'h00020001)
    bus(0, 16'h1000, 0); `CHK(r, 32'h0)
    `CHK(capl, 1'b1)
    for (int k = 0; k < 6; k++) begin
      m = (k == 0) ? 32'h0 : (k == 1) ? 32'hffff : xs();
      bus(1, 16'h105c, m); bus(0, 16'h105c, 0); `CHK(r, m & 32'hfffe)
      `CHK(priv, m[2])
      bus(1, 16'h1044, 32'h7f); bus(1, 16'h1048, 32'h7f);
      for (int i = 0; i < 6; i++) begin
        @(posedge clk);
        pe <= '{16'h1 << st[i], 1'b0};
        se <= '{16'h1 << st[i], 1'b0};
        ep[i] = !m[pm[i]];
        es[i] = !m[sm[i]];
      end
      ep[6] = !m[1];
      es[6] = !m[3];
      @(posedge clk); pe <= '0; se <= '0; psw <= 1; psn <= 2'b11; srb <= 1;
      @(posedge clk); psw <= 0; srb <= 0;
      @(posedge clk); psw <= 1; psn <= 2'b00;
      @(posedge clk); psw <= 0;
      repeat (4) @(posedge clk);
      #1;
      `CHK(pis, ep)
      `CHK(sis, es)
      bus(0, 16'h1044, 0); `CHK(r[6:0], ep)
    end
    test_done();
  end
endmodule
